// ### pkg/pwm_out_pkg.sv
// shared constants for the pwm output override and fault disable block
package pwm_out_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_OVERRIDE = 8'h04;
	localparam logic [7:0] OFS_DISABLE_MAP_REGISTER = 8'h08;
	localparam logic [7:0] OFS_FAULT_CTRL = 8'h0c;
	localparam logic [7:0] OFS_FAULT_STAT = 8'h10;
	localparam logic [7:0] OFS_DEAD_TIME = 8'h14;
	localparam logic [7:0] OFS_MODULUS = 8'h18;
	// ------------------------------------------------------------
	// control register bit positions
	// ------------------------------------------------------------
	localparam int B_EN = 0;
	localparam int B_OVR = 1;
	localparam int B_COMP = 2;
	localparam int B_DIS_X = 3;
	localparam int B_DIS_Y = 4;
	localparam int B_RL_IE = 5;
	localparam int B_RL_FLAG = 6;
	localparam int B_PRSC = 8;
	localparam int B_TOP_NEG = 10;
	localparam int B_BOT_NEG = 11;
	// ------------------------------------------------------------
	// fault register field positions
	// ------------------------------------------------------------
	localparam int B_FAULT_RECOVERY_MODE = 0;
	localparam int B_FIE = 4;
	localparam int B_FAULT_PIN_STATE = 0;
	localparam int B_FAULT_EVENT_FLAG = 4;
	localparam int B_FACK = 0;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DEAD_TIME = 8'h10;
	localparam logic [11:0] RST_MODULUS = 12'h100;
	localparam logic [11:0] RST_DISABLE_MAP_REGISTER = 12'hfff;
	localparam logic [1:0] PRSC_DIV1 = 2'h0;
endpackage

// ### pkg/dead_time_if.sv
// carrier between the output stage and one dead-time pair
`timescale 1ns/1ps
`default_nettype none
interface dead_time_if;
	logic top_req;
	logic bot_req;
	logic comp;
	logic [7:0] dt;
	logic top_out;
	logic bot_out;
	modport drv (output top_req, output bot_req, output comp, output dt,
		input top_out, input bot_out);
	modport pair (input top_req, input bot_req, input comp, input dt,
		output top_out, output bot_out);
endinterface
`default_nettype wire

// ### logic/fault_filter.sv
// synchroniser and glitch filter for one fault input
`timescale 1ns/1ps
`default_nettype none
module fault_filter (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_fault,
	output logic o_pin,
	output logic o_rise
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic low_seen;
		logic hi_once;
		logic pin;
		logic rise;
	} ff_type;
	ff_type s_ff, nxt_s;
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sync1 = i_fault;
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.rise = 1'b0;
		if (!s_ff.pin) begin
			if (!s_ff.sync2) begin
				nxt_s.low_seen = 1'b1;
				nxt_s.hi_once = 1'b0;
			end else if (s_ff.low_seen) begin
				if (s_ff.hi_once) begin
					nxt_s.pin = 1'b1;
					nxt_s.rise = 1'b1;
					nxt_s.low_seen = 1'b0;
					nxt_s.hi_once = 1'b0;
				end else begin
					nxt_s.hi_once = 1'b1;
				end
			end
		end else if (!s_ff.sync2) begin
			nxt_s.pin = 1'b0;
			nxt_s.low_seen = 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign o_pin = s_ff.pin;
	assign o_rise = s_ff.rise;
endmodule
`default_nettype wire

// ### logic/dead_time_pair.sv
// dead-time insertion for one top/bottom pair
`timescale 1ns/1ps
`default_nettype none
module dead_time_pair (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	dead_time_if.pair pif
);
	typedef struct packed {
		logic prev;
		logic [7:0] cnt;
		logic top;
		logic bot;
	} dt_type;
	dt_type s_ff, nxt_s;
	always_comb begin
		nxt_s = s_ff;
		if (!pif.comp) begin
			nxt_s.prev = pif.top_req;
			nxt_s.cnt = 8'h00;
			nxt_s.top = pif.top_req;
			nxt_s.bot = pif.bot_req;
		end else if (pif.top_req != s_ff.prev) begin
			nxt_s.prev = pif.top_req;
			nxt_s.cnt = pif.dt;
			nxt_s.top = 1'b0;
			nxt_s.bot = 1'b0;
		end else if (s_ff.cnt != 8'h00) begin
			nxt_s.cnt = s_ff.cnt - 8'h01;
			nxt_s.top = 1'b0;
			nxt_s.bot = 1'b0;
		end else begin
			nxt_s.top = pif.top_req;
			nxt_s.bot = pif.bot_req & ~pif.top_req;
		end
	end
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign pif.top_out = s_ff.top;
	assign pif.bot_out = s_ff.bot;
endmodule
`default_nettype wire

// ### logic/pwm_output_stage.sv
// six-channel pwm output stage with override and fault disable
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_stage (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic [5:0] i_gen_level,
	input wire logic [3:0] i_fault,
	output logic [5:0] o_pwm,
	output logic [5:0] o_pwm_oe,
	output logic [3:0] o_fault_irq,
	output logic o_reload_irq,
	output logic o_cycle_start,
	output logic o_first_reload
);
	import pwm_out_pkg::*;
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic [31:0] rdata;
		logic en;
		logic ovr;
		logic comp;
		logic top_neg;
		logic bot_neg;
		logic dis_x;
		logic dis_y;
		logic rl_ie;
		logic rl_flag;
		logic rl_armed;
		logic rl_irq;
		logic [1:0] prsc;
		logic [5:0] lvl;
		logic [11:0] map;
		logic map_lock;
		logic [3:0] fault_recovery_mode;
		logic [3:0] fie;
		logic [3:0] fault_event_flag;
		logic [3:0] firq;
		logic [3:0] fdis;
		logic [1:0] sdis;
		logic [7:0] dt;
		logic [11:0] modulus;
		logic [11:0] cnt;
		logic [2:0] pre;
		logic cyc;
		logic first;
		logic src_ovr;
		logic drive;
		logic drive_wait;
		logic [5:0] pin;
		logic [5:0] oe;
	} st_type;
	st_type s_ff, nxt_s;
	logic [3:0] f_pin;
	logic [3:0] f_rise;
	logic [5:0] req;
	logic [2:0] dt_top;
	logic [2:0] dt_bot;
	dead_time_if pif[3] ();
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return r;
	endfunction
	function automatic logic [2:0] pre_mask(input logic [1:0] sel);
		logic [2:0] m;
		case (sel)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			default: m = 3'h7;
		endcase
		return m;
	endfunction
	function automatic logic [31:0] ctrl_word(input st_type s);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[B_EN] = s.en;
		r[B_OVR] = s.ovr;
		r[B_COMP] = s.comp;
		r[B_DIS_X] = s.dis_x;
		r[B_DIS_Y] = s.dis_y;
		r[B_RL_IE] = s.rl_ie;
		r[B_RL_FLAG] = s.rl_flag;
		r[B_PRSC +: 2] = s.prsc;
		r[B_TOP_NEG] = s.top_neg;
		r[B_BOT_NEG] = s.bot_neg;
		return r;
	endfunction
	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_flt
			fault_filter u_flt (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_fault(i_fault[g]),
				.o_pin(f_pin[g]),
				.o_rise(f_rise[g])
			);
		end
		for (g = 0; g < 3; g++) begin : g_dt
			assign pif[g].top_req = req[2*g];
			assign pif[g].bot_req = req[2*g+1];
			assign pif[g].comp = s_ff.comp;
			assign pif[g].dt = s_ff.dt;
			assign dt_top[g] = pif[g].top_out;
			assign dt_bot[g] = pif[g].bot_out;
			dead_time_pair u_dt (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.pif(pif[g])
			);
		end
	endgenerate
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic acc;
		logic wr_ctrl;
		logic [31:0] w;
		logic [5:0] gen;
		logic tick;
		logic clr_ok;
		logic bx;
		logic by;
		logic [5:0] mask;
		logic [5:0] act;
		acc = 1'b0;
		wr_ctrl = 1'b0;
		w = 32'h0000_0000;
		gen = 6'h00;
		tick = 1'b0;
		clr_ok = 1'b0;
		bx = 1'b0;
		by = 1'b0;
		mask = 6'h00;
		act = 6'h00;
		req = 6'h00;
		nxt_s = s_ff;
		nxt_s.cyc = 1'b0;
		nxt_s.first = 1'b0;
		nxt_s.wr = !((i_read || i_write) && s_ff.wr);
		acc = (i_read || i_write) && !s_ff.wr;
		if ((i_read || i_write) && s_ff.wr) begin
			case (i_address)
				OFS_CTRL: nxt_s.rdata = ctrl_word(s_ff);
				OFS_OVERRIDE: nxt_s.rdata = {26'h0, s_ff.lvl};
				OFS_DISABLE_MAP_REGISTER: nxt_s.rdata = {20'h0, s_ff.map};
				OFS_FAULT_CTRL: nxt_s.rdata = {24'h0, s_ff.fie, s_ff.fault_recovery_mode};
				OFS_FAULT_STAT: nxt_s.rdata = {24'h0, s_ff.fault_event_flag, f_pin};
				OFS_DEAD_TIME: nxt_s.rdata = {24'h0, s_ff.dt};
				OFS_MODULUS: nxt_s.rdata = {20'h0, s_ff.modulus};
				default: nxt_s.rdata = 32'h0000_0000;
			endcase
		end
		if (acc && i_read && i_address == OFS_CTRL && s_ff.rl_flag) begin
			nxt_s.rl_armed = 1'b1;
		end
		if (acc && i_write) begin
			case (i_address)
				OFS_CTRL: begin
					w = merge(ctrl_word(s_ff), i_writedata, i_byteenable);
					wr_ctrl = 1'b1;
					nxt_s.en = w[B_EN];
					nxt_s.ovr = w[B_OVR];
					nxt_s.comp = w[B_COMP];
					nxt_s.dis_x = w[B_DIS_X];
					nxt_s.dis_y = w[B_DIS_Y];
					nxt_s.rl_ie = w[B_RL_IE];
					nxt_s.prsc = w[B_PRSC +: 2];
					nxt_s.top_neg = w[B_TOP_NEG];
					nxt_s.bot_neg = w[B_BOT_NEG];
					if (!w[B_RL_FLAG] && s_ff.rl_armed) begin
						nxt_s.rl_flag = 1'b0;
					end
					nxt_s.rl_armed = 1'b0;
				end
				OFS_OVERRIDE: begin
					w = merge({26'h0, s_ff.lvl}, i_writedata, i_byteenable);
					nxt_s.lvl = w[5:0];
				end
				OFS_DISABLE_MAP_REGISTER: begin
					if (!s_ff.map_lock) begin
						w = merge({20'h0, s_ff.map}, i_writedata, i_byteenable);
						nxt_s.map = w[11:0];
						nxt_s.map_lock = 1'b1;
					end
				end
				OFS_FAULT_CTRL: begin
					w = merge({24'h0, s_ff.fie, s_ff.fault_recovery_mode}, i_writedata,
						i_byteenable);
					nxt_s.fault_recovery_mode = w[B_FAULT_RECOVERY_MODE +: 4];
					nxt_s.fie = w[B_FIE +: 4];
					nxt_s.firq = s_ff.firq & w[B_FIE +: 4];
				end
				OFS_FAULT_STAT: begin
					if (i_byteenable[0]) begin
						nxt_s.fault_event_flag = s_ff.fault_event_flag & ~i_writedata[B_FACK +: 4];
						nxt_s.firq = nxt_s.firq & ~i_writedata[B_FACK +: 4];
					end
				end
				OFS_DEAD_TIME: begin
					w = merge({24'h0, s_ff.dt}, i_writedata, i_byteenable);
					nxt_s.dt = w[7:0];
				end
				OFS_MODULUS: begin
					w = merge({20'h0, s_ff.modulus}, i_writedata, i_byteenable);
					nxt_s.modulus = w[11:0];
				end
				default: ;
			endcase
		end
		gen = s_ff.en ? i_gen_level : 6'h00;
		if (!s_ff.en) begin
			nxt_s.cnt = 12'h000;
			nxt_s.pre = 3'h0;
			nxt_s.drive = 1'b0;
			nxt_s.drive_wait = 1'b0;
		end else if (s_ff.pre == pre_mask(s_ff.prsc)) begin
			nxt_s.pre = 3'h0;
			if (s_ff.cnt + 12'h001 >= s_ff.modulus) begin
				nxt_s.cnt = 12'h000;
				nxt_s.cyc = 1'b1;
			end else begin
				nxt_s.cnt = s_ff.cnt + 12'h001;
			end
		end else begin
			nxt_s.pre = s_ff.pre + 3'h1;
		end
		if (s_ff.cyc) begin
			nxt_s.rl_flag = 1'b1;
			nxt_s.rl_armed = 1'b0;
			if (s_ff.drive_wait) begin
				nxt_s.drive = 1'b1;
				nxt_s.drive_wait = 1'b0;
			end
		end
		if (wr_ctrl && nxt_s.en && !s_ff.en) begin
			nxt_s.rl_flag = 1'b1;
			nxt_s.rl_armed = 1'b0;
			nxt_s.first = 1'b1;
			if (nxt_s.prsc == PRSC_DIV1) begin
				nxt_s.drive = 1'b1;
			end else begin
				nxt_s.drive_wait = 1'b1;
			end
		end
		nxt_s.rl_irq = nxt_s.rl_flag && nxt_s.rl_ie;
		if (s_ff.ovr) begin
			nxt_s.src_ovr = 1'b1;
		end else if (s_ff.cyc || !s_ff.en) begin
			nxt_s.src_ovr = 1'b0;
		end
		tick = s_ff.cyc || s_ff.src_ovr;
		for (int i = 0; i < 4; i++) begin
			if (s_ff.fault_recovery_mode[i]) begin
				clr_ok = !f_pin[i];
			end else begin
				clr_ok = !s_ff.fault_event_flag[i] && ((i % 2 == 0) || !f_pin[i]);
			end
			if (tick && clr_ok) begin
				nxt_s.fdis[i] = 1'b0;
			end
			if (f_rise[i]) begin
				nxt_s.fdis[i] = 1'b1;
				nxt_s.fault_event_flag[i] = 1'b1;
				if (nxt_s.fie[i]) begin
					nxt_s.firq[i] = 1'b1;
				end
			end
		end
		nxt_s.sdis[0] = s_ff.dis_x || (s_ff.sdis[0] && !tick);
		nxt_s.sdis[1] = s_ff.dis_y || (s_ff.sdis[1] && !tick);
		for (int p = 0; p < 3; p++) begin
			if (s_ff.src_ovr) begin
				req[2*p] = s_ff.lvl[2*p];
				if (s_ff.comp) begin
					req[2*p+1] = s_ff.lvl[2*p+1] && !s_ff.lvl[2*p];
				end else begin
					req[2*p+1] = s_ff.lvl[2*p+1];
				end
			end else begin
				req[2*p] = gen[2*p];
				req[2*p+1] = s_ff.comp ? !gen[2*p] : gen[2*p+1];
			end
			act[2*p] = dt_top[p];
			act[2*p+1] = dt_bot[p];
		end
		bx = s_ff.fdis[0] || s_ff.fdis[1] || s_ff.sdis[0] || s_ff.dis_x;
		by = s_ff.fdis[2] || s_ff.fdis[3] || s_ff.sdis[1] || s_ff.dis_y;
		mask = (bx ? s_ff.map[5:0] : 6'h00) | (by ? s_ff.map[11:6] : 6'h00);
		nxt_s.pin = (act & ~mask)
			^ {3{s_ff.bot_neg, s_ff.top_neg}};
		nxt_s.oe = {6{(s_ff.drive && s_ff.en) || s_ff.ovr}};
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '0;
			s_ff.wr <= 1'b1;
			s_ff.map <= RST_DISABLE_MAP_REGISTER;
			s_ff.dt <= RST_DEAD_TIME;
			s_ff.modulus <= RST_MODULUS;
		end else begin
			s_ff <= nxt_s;
		end
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_readdata = s_ff.rdata;
	assign o_waitrequest = s_ff.wr;
	assign o_pwm = s_ff.pin;
	assign o_pwm_oe = s_ff.oe;
	assign o_fault_irq = s_ff.firq;
	assign o_reload_irq = s_ff.rl_irq;
	assign o_cycle_start = s_ff.cyc;
	assign o_first_reload = s_ff.first;
endmodule
`default_nettype wire

// ### tb/pwm_out_properties.sv
// concurrent checks on the pwm output stage ports
`timescale 1ns/1ps
`default_nettype none
module pwm_out_properties (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic o_waitrequest,
	input wire logic [3:0] i_fault,
	input wire logic [5:0] o_pwm,
	input wire logic [5:0] o_pwm_oe,
	input wire logic [3:0] o_fault_irq,
	input wire logic o_first_reload
);
	import pwm_out_pkg::*;
	logic [4:0] cfg_ff;
	logic [5:0] act;
	logic run;
	logic ctl_acc;
	assign ctl_acc = i_write && !o_waitrequest && i_address == OFS_CTRL
		&& i_byteenable[1:0] == 2'h3;
	assign act = o_pwm ^ {3{cfg_ff[4], cfg_ff[3]}};
	assign run = cfg_ff[0] || cfg_ff[1];
	// shadow of enable, override, mode and polarity bits
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_ff <= 5'h00;
		end else if (ctl_acc) begin
			cfg_ff <= {i_writedata[B_BOT_NEG], i_writedata[B_TOP_NEG],
				i_writedata[B_COMP], i_writedata[B_OVR], i_writedata[B_EN]};
		end
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	sequence en_on;
		ctl_acc && i_writedata[B_EN] && !run
			&& i_writedata[B_PRSC+:2] == PRSC_DIV1;
	endsequence
	sequence oe_up;
		!o_pwm_oe[0] ##1 o_pwm_oe[0];
	endsequence
	wait_grant_a: assert property (
		(i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("waitrequest stayed high");
	wait_single_a: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low too long");
	oe_uniform_a: assert property (
		o_pwm_oe == 6'h00 || o_pwm_oe == 6'h3f)
		else $error("enables differ");
	en_drive_a: assert property (en_on |=> oe_up)
		else $error("pins not driven after enable");
	first_load_a: assert property (
		en_on |-> ##[1:3] o_first_reload)
		else $error("no reload at enable");
	oe_off_a: assert property (
		!run && !$past(run, 4) |-> o_pwm_oe == 6'h00)
		else $error("pins driven while disabled");
	pair_apart_a: assert property (
		cfg_ff[2] && o_pwm_oe[0] && cfg_ff == $past(cfg_ff, 4)
		|-> !(act[0] && act[1]) && !(act[2] && act[3])
		&& !(act[4] && act[5]))
		else $error("pair active together");
	for (genvar k = 0; k < 4; k++) begin : g_f
		filter_irq_a: assert property (
			$rose(o_fault_irq[k])
			|-> $past(i_fault[k], 4) && $past(i_fault[k], 5))
			else $error("fault request without fault");
		irq_ack_a: assert property (
			i_write && !o_waitrequest && i_address == OFS_FAULT_STAT
			&& i_byteenable[0] && i_writedata[k]
			|-> ##[1:2] !o_fault_irq[k])
			else $error("fault request kept after ack");
	end
endmodule
`default_nettype wire

// ### tb/fault_sense_model.sv
// fault sensor model on the power stage side
`timescale 1ns/1ps
`default_nettype none
module fault_sense_model (
	input wire logic i_ref_clk,
	input wire logic [3:0] i_trip,
	input wire logic [3:0] i_blip,
	output logic [3:0] o_fault
);
	initial o_fault = 4'h0;
	// a trip holds the pin high, a blip lasts one clock
	always @(posedge i_ref_clk) o_fault <= i_trip | i_blip;
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pwm_out_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [5:0] gen = 6'h00;
	logic [3:0] trip = 4'h0;
	logic [3:0] blip = 4'h0;
	logic [3:0] flt, firq;
	logic [31:0] rdat;
	logic [5:0] pwm, oe;
	logic wreq, rirq, cyc, frl;
	int err_total = 0;
	int compares = 0;
	pwm_output_stage dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd),
		.i_byteenable(4'hf), .o_readdata(rdat), .o_waitrequest(wreq),
		.i_gen_level(gen), .i_fault(flt), .o_pwm(pwm), .o_pwm_oe(oe),
		.o_fault_irq(firq), .o_reload_irq(rirq), .o_cycle_start(cyc),
		.o_first_reload(frl));
	fault_sense_model fsm (.i_ref_clk(i_ref_clk), .i_trip(trip),
		.i_blip(blip), .o_fault(flt));
	initial begin
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_ref_clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do begin
			@(posedge i_ref_clk);
		end while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(nm, e, q);
	endtask
	task automatic pin(input logic [5:0] e);
		tick(12);
		cmp("pins", {26'h0, e}, {26'h0, pwm});
	endtask
	task automatic wcyc;
		repeat (5000) begin
			@(posedge i_ref_clk);
			if (cyc === 1'b1) break;
		end
		cmp("cycle start", 32'h1, {31'h0, cyc});
	endtask
	function automatic logic [5:0] pins(input logic [11:0] c,
		input logic [5:0] l);
		logic [5:0] a;
		a = l;
		for (int k = 1; k < 6; k += 2) begin
			if (c[B_COMP]) a[k] = l[k] & ~l[k-1];
		end
		return a ^ {3{c[B_BOT_NEG], c[B_TOP_NEG]}};
	endfunction
	task automatic t_regs;
		rdc("dead time", OFS_DEAD_TIME, {24'h0, RST_DEAD_TIME});
		rdc("modulus", OFS_MODULUS, {20'h0, RST_MODULUS});
		rdc("map", OFS_DISABLE_MAP_REGISTER, {20'h0, RST_DISABLE_MAP_REGISTER});
		rdc("unmapped", 8'h1c, 32'h0);
		wrt(OFS_DISABLE_MAP_REGISTER, 32'hc03);
		wrt(OFS_DISABLE_MAP_REGISTER, 32'hfff);
		rdc("map", OFS_DISABLE_MAP_REGISTER, 32'hc03);
		wrt(OFS_DEAD_TIME, 32'h4);
		wrt(OFS_MODULUS, 32'h40);
		$display("t_regs done");
	endtask
	task automatic t_ovr;
		logic [11:0] md [4];
		logic [5:0] lv [4];
		md = '{12'h002, 12'h402, 12'h006, 12'h806};
		lv = '{6'h2d, 6'h2d, 6'h0e, 6'h0e};
		for (int i = 0; i < 4; i++) begin
			wrt(OFS_OVERRIDE, 32'h0);
			wrt(OFS_CTRL, {20'h0, md[i]});
			wrt(OFS_OVERRIDE, {26'h0, lv[i]});
			pin(pins(md[i], lv[i]));
			cmp("enable", 32'h3f, {26'h0, oe});
		end
		wrt(OFS_OVERRIDE, 32'h0);
		$display("t_ovr done");
	endtask
	task automatic t_fault;
		wrt(OFS_CTRL, 32'h2);
		wrt(OFS_OVERRIDE, 32'h3f);
		wrt(OFS_FAULT_CTRL, 32'hff);
		blip <= 4'h1;
		tick(1);
		blip <= 4'h0;
		tick(8);
		rdc("short pulse", OFS_FAULT_STAT, 32'h0);
		trip <= 4'h2;
		pin(6'h3c);
		rdc("status", OFS_FAULT_STAT, 32'h22);
		cmp("irq", 32'h2, {28'h0, firq});
		trip <= 4'h0;
		pin(6'h3f);
		rdc("status", OFS_FAULT_STAT, 32'h20);
		wrt(OFS_FAULT_STAT, 32'h2);
		rdc("status", OFS_FAULT_STAT, 32'h0);
		cmp("irq", 32'h0, {28'h0, firq});
		trip <= 4'h4;
		pin(6'h0f);
		wrt(OFS_FAULT_CTRL, 32'h0f);
		rdc("status", OFS_FAULT_STAT, 32'h44);
		cmp("irq", 32'h0, {28'h0, firq});
		trip <= 4'h0;
		wrt(OFS_FAULT_STAT, 32'h4);
		wrt(OFS_FAULT_CTRL, 32'hf0);
		trip <= 4'h1;
		pin(6'h3c);
		wrt(OFS_FAULT_STAT, 32'h1);
		pin(6'h3f);
		trip <= 4'h2;
		pin(6'h3c);
		wrt(OFS_FAULT_STAT, 32'h2);
		pin(6'h3c);
		trip <= 4'h0;
		pin(6'h3f);
		wrt(OFS_CTRL, 32'h0a);
		pin(6'h3c);
		rdc("status", OFS_FAULT_STAT, 32'h0);
		cmp("irq", 32'h0, {28'h0, firq});
		wrt(OFS_CTRL, 32'h02);
		pin(6'h3f);
		wrt(OFS_OVERRIDE, 32'h0);
		wrt(OFS_CTRL, 32'h0);
		$display("t_fault done");
	endtask
	task automatic t_en;
		gen <= 6'h15;
		wrt(OFS_CTRL, 32'h21);
		tick(1);
		cmp("first reload", 32'h1, {31'h0, frl});
		tick(2);
		cmp("enable", 32'h3f, {26'h0, oe});
		rdc("control", OFS_CTRL, 32'h61);
		cmp("reload irq", 32'h1, {31'h0, rirq});
		wcyc;
		pin(6'h15);
		wrt(OFS_CTRL, 32'h23);
		wrt(OFS_OVERRIDE, 32'h2);
		pin(6'h02);
		wcyc;
		wrt(OFS_OVERRIDE, 32'h0);
		wcyc;
		wrt(OFS_CTRL, 32'h21);
		tick(8);
		cmp("pins", 32'h0, {26'h0, pwm});
		wcyc;
		pin(6'h15);
		wrt(OFS_CTRL, 32'h20);
		tick(4);
		cmp("enable", 32'h0, {26'h0, oe});
		rdc("control", OFS_CTRL, 32'h60);
		wrt(OFS_CTRL, 32'h121);
		tick(3);
		cmp("enable", 32'h0, {26'h0, oe});
		wcyc;
		tick(3);
		cmp("enable", 32'h3f, {26'h0, oe});
		$display("t_en done");
	endtask
	initial begin
		tick(20);
		i_rst <= 1'b0;
		t_regs;
		t_ovr;
		t_fault;
		t_en;
		conclude;
	end
	initial begin
		#100us;
		err_total++;
		conclude;
	end
endmodule
bind pwm_output_stage pwm_out_properties chk (.i_ref_clk(i_ref_clk),
	.i_rst(i_rst), .i_address(i_address), .i_read(i_read),
	.i_write(i_write), .i_writedata(i_writedata),
	.i_byteenable(i_byteenable), .o_waitrequest(o_waitrequest),
	.i_fault(i_fault), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe),
	.o_fault_irq(o_fault_irq), .o_first_reload(o_first_reload));
`default_nettype wire
